//--- apd_buf2.sv
/*
 * apd_buf2: two-entry buffer for captured read words, output side is a
 * register. Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
module apd_buf2 import apd_pkg::*; (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              in_valid_i,
   output logic                   in_ready_o,
   input  wire logic [DATA_W-1:0] in_data_i,
   output logic                   out_valid_o,
   input  wire logic              out_ready_i,
   output logic [DATA_W-1:0]      out_data_o
);

   logic              out_v_reg, out_v_next;
   logic [DATA_W-1:0] out_d_reg, out_d_next;
   logic              sk_v_reg,  sk_v_next;
   logic [DATA_W-1:0] sk_d_reg,  sk_d_next;

   // ---------------------------------------------------------------
   // next state: drain first, then refill from the spare slot
   // ---------------------------------------------------------------
   always_comb begin
      out_v_next = out_v_reg;
      out_d_next = out_d_reg;
      sk_v_next  = sk_v_reg;
      sk_d_next  = sk_d_reg;
      if (out_v_reg && out_ready_i) begin
         out_v_next = 1'b0;
      end
      if (sk_v_reg && !out_v_next) begin
         out_v_next = 1'b1;
         out_d_next = sk_d_reg;
         sk_v_next  = 1'b0;
      end
      // spare slot is free whenever in_ready_o is high
      if (in_valid_i && !sk_v_reg) begin
         if (!out_v_next) begin
            out_v_next = 1'b1;
            out_d_next = in_data_i;
         end else begin
            sk_v_next = 1'b1;
            sk_d_next = in_data_i;
         end
      end
   end

   // registers
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_v_reg <= 1'b0;
         out_d_reg <= '0;
         sk_v_reg  <= 1'b0;
         sk_d_reg  <= '0;
      end else begin
         out_v_reg <= out_v_next;
         out_d_reg <= out_d_next;
         sk_v_reg  <= sk_v_next;
         sk_d_reg  <= sk_d_next;
      end
   end

   assign in_ready_o  = !sk_v_reg;  // full only when both slots hold words
   assign out_valid_o = out_v_reg;
   assign out_data_o  = out_d_reg;

endmodule // apd_buf2

//--- apd_disp_model.sv
/* apd_disp_model: display panel on the parallel port, read side only.
   assumes pins are synchronous to the single reference clock. */
`timescale 1ns/10ps
module apd_disp_model import apd_pkg::*; (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              rd_pin_i,
   input  wire logic              rd_pol_i,
   input  wire logic              stall_i,
   output logic                   wait_o,
   output logic [DATA_W-1:0]      data_o,
   output logic [DATA_W-1:0]      word_o
);
   // ----------------------------------------------------------
   // read bus and wait
   // ----------------------------------------------------------
   logic              rd_act;
   logic              rd_was;
   logic [DATA_W-1:0] last;
   assign rd_act = (rd_pin_i === rd_pol_i);
   assign data_o = rd_act ? word_o : ~last; // released bus: inverse, never stale
   assign wait_o = stall_i;
   // new word after each strobe, so reads can be told apart
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_was <= 1'b0;
         last   <= 16'h0000;
         word_o <= 16'hA5C3;
      end else begin
         rd_was <= rd_act;
         if (rd_act) last <= word_o;
         if (rd_was && !rd_act) word_o <= word_o + 16'h0111;
      end
   end
endmodule // apd_disp_model

//--- apd_pkg.sv
/*
 * apd_pkg: shared constants for the asynchronous parallel display strobe
 * generator. Assumes every timing setting is given in reference clock
 * cycles of 8 ns and that the base clock period setting is even.
 */
package apd_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DATA_W   = 16;   // display data bus
   localparam int TIME_W   = 8;    // every programmed time field
   localparam int ACC_W    = 12;   // half-step time accumulator

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int REF_CLK_PERIOD_NS = 8;
   localparam int WAIT_DELAY_BASE   = 2;  // base-clock cycles of wait latency
   localparam logic [1:0] GAP_HALF_STEPS = 2'h2; // one base period idle gap

   // ---------------------------------------------------------------
   // access kinds
   // ---------------------------------------------------------------
   localparam logic [1:0] KIND_READ  = 2'h0;
   localparam logic [1:0] KIND_WADDR = 2'h1;
   localparam logic [1:0] KIND_WDATA = 2'h2;

   // ---------------------------------------------------------------
   // control line index, also bit position in the polarity setting
   // ---------------------------------------------------------------
   localparam int LINE_CS = 0;
   localparam int LINE_RS = 1;
   localparam int LINE_RD = 2;
   localparam int LINE_WR = 3;
   localparam int LINE_N  = 4;

   // polarity bit 0 means active low
   localparam logic [3:0] POL_RESET = 4'h0;

   typedef enum logic [1:0] {
      APD_IDLE,
      APD_ACCESS,
      APD_GAP
   } apd_state_t;

endpackage

//--- apd_strobe_gen.sv
/*
 * apd_strobe_gen: access-level timing for a system 80 / 68k style
 * asynchronous parallel display port. Assumes the settings stay stable
 * during an access, pins are synchronous to ref_clk_i, and the base clock
 * period setting is an even count of reference cycles, at least 2.
 */
`timescale 1ns/10ps
// What this block does
// - Each control line has a software polarity bit; zero means active low.
// - Read, address write and data write each use their own access length.
// - Access lasts programmed length rounded up to whole base-clock periods, at least one period.
// - Chip select asserts at its up point, rounded up to half periods.
// - Chip select releases at its down point, rounded up to half periods.
// - Register select switches at its own up and down half-period points.
// - Read strobe pulses only in reads, between its up and down points.
// - Write strobe pulses only in writes, between its up and down points.
// - One read data capture per read, at operand rounded up to periods.
// - Capture point comes from the operand given with the read command.
// - Wait acts two base clocks late; current access ends, next one held.
// - Single access mode idles all control lines one base period after access.
module apd_strobe_gen import apd_pkg::*; (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic [3:0]        control_polarity_setting_i,
   input  wire logic [TIME_W-1:0] base_clock_period_setting_i,
   input  wire logic [TIME_W-1:0] access_len_read_i,
   input  wire logic [TIME_W-1:0] access_len_waddr_i,
   input  wire logic [TIME_W-1:0] access_len_wdata_i,
   input  wire logic [TIME_W-1:0] cs_assert_point_i,
   input  wire logic [TIME_W-1:0] cs_release_point_i,
   input  wire logic [TIME_W-1:0] rs_assert_point_i,
   input  wire logic [TIME_W-1:0] rs_release_point_i,
   input  wire logic [TIME_W-1:0] rd_assert_point_i,
   input  wire logic [TIME_W-1:0] rd_release_point_i,
   input  wire logic [TIME_W-1:0] wr_assert_point_i,
   input  wire logic [TIME_W-1:0] wr_release_point_i,
   input  wire logic              single_mode_i,
   input  wire logic              cmd_valid_i,
   output logic                   cmd_ready_o,
   input  wire logic [1:0]        cmd_kind_i,
   input  wire logic [DATA_W-1:0] cmd_wdata_i,
   input  wire logic [TIME_W-1:0] read_capture_operand_i,
   input  wire logic              display_wait_input_i,
   input  wire logic [DATA_W-1:0] disp_data_i,
   output logic [DATA_W-1:0]      disp_data_o,
   output logic                   disp_data_oe_b_o,
   output logic                   chip_select_o,
   output logic                   register_select_o,
   output logic                   read_strobe_o,
   output logic                   write_strobe_o,
   output logic                   rdata_valid_o,
   input  wire logic              rdata_ready_i,
   output logic [DATA_W-1:0]      rdata_o,
   output logic                   busy_o
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // time value doubled to accumulator width
   function automatic logic [ACC_W-1:0] dbl(input logic [TIME_W-1:0] t);
      return {3'h0, t, 1'b0};
   endfunction

   // line is active from ceil(2*up/P) to ceil(2*max(dn,up)/P) half steps
   function automatic logic in_win(input logic [ACC_W-1:0] acc,
                                   input logic [TIME_W-1:0] up,
                                   input logic [TIME_W-1:0] dn);
      logic [TIME_W-1:0] dn_c;
      dn_c = (dn < up) ? up : dn;
      return (acc >= dbl(up)) && (acc < dbl(dn_c));
   endfunction

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   apd_state_t        state_reg, state_next;
   logic [1:0]        kind_reg, kind_next;
   logic [DATA_W-1:0] wd_reg, wd_next;
   logic [TIME_W-1:0] op_reg, op_next;
   logic [ACC_W-1:0]  acc_reg, acc_next;
   logic              ph_reg, ph_next;
   logic [TIME_W-2:0] div_reg, div_next;
   logic              wph_reg, wph_next;
   logic [1:0]        wait_q_reg, wait_q_next;
   logic              cap_reg, cap_next;
   logic [1:0]        gcnt_reg, gcnt_next;
   logic              rdy_reg, rdy_next;
   logic [3:0]        act_reg, act_next;
   logic [3:0]        pin_reg, pin_next;
   logic              oe_b_reg, oe_b_next;
   logic              busy_reg, busy_next;
   logic [TIME_W-2:0] half_len;
   logic              half_tick, start, end_now, cap_now;
   logic [TIME_W-1:0] len_sel;
   logic [TIME_W-1:0] up_a [LINE_N];
   logic [TIME_W-1:0] dn_a [LINE_N];
   logic [3:0]        line_en;
   logic              buf_in_ready;

   assign up_a[LINE_CS] = cs_assert_point_i;
   assign dn_a[LINE_CS] = cs_release_point_i;
   assign up_a[LINE_RS] = rs_assert_point_i;
   assign dn_a[LINE_RS] = rs_release_point_i;
   assign up_a[LINE_RD] = rd_assert_point_i;
   assign dn_a[LINE_RD] = rd_release_point_i;
   assign up_a[LINE_WR] = wr_assert_point_i;
   assign dn_a[LINE_WR] = wr_release_point_i;

   // half a base period in reference cycles, never below one
   assign half_len  = (base_clock_period_setting_i[TIME_W-1:1] == '0) ? 7'h01
                                                                        : base_clock_period_setting_i[TIME_W-1:1];
   // >= so a period setting shrunk mid-count cannot leave the divider wrapping
   assign half_tick = (div_reg >= half_len - 7'h01);
   assign start     = (state_reg == APD_IDLE) && cmd_valid_i && rdy_reg;

   always_comb begin
      case (kind_reg)
         KIND_READ:  len_sel = access_len_read_i;
         KIND_WADDR: len_sel = access_len_waddr_i;
         default:    len_sel = access_len_wdata_i;
      endcase
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_next  = state_reg;
      kind_next   = kind_reg;
      wd_next     = wd_reg;
      op_next     = op_reg;
      acc_next    = acc_reg;
      ph_next     = ph_reg;
      cap_next    = cap_reg;
      gcnt_next   = gcnt_reg;
      wph_next    = half_tick ? ~wph_reg : wph_reg;
      div_next    = half_tick ? '0 : div_reg + 7'h01;
      end_now     = 1'b0;
      cap_now     = 1'b0;
      // wait pipeline, two base periods deep
      wait_q_next = (half_tick && wph_reg) ? {wait_q_reg[0], display_wait_input_i} : wait_q_reg;
      case (state_reg)
         APD_IDLE: begin
            if (start) begin
               // operand latched with the read command
               state_next = APD_ACCESS;
               kind_next  = cmd_kind_i;
               wd_next    = cmd_wdata_i;
               op_next    = read_capture_operand_i;
               acc_next   = '0;
               ph_next    = 1'b0;
               cap_next   = 1'b0;
               div_next   = '0;
            end
         end
         APD_ACCESS: begin
            if (half_tick) begin
               acc_next = acc_reg + {4'h0, base_clock_period_setting_i};
               ph_next  = ~ph_reg;
               // end on a whole period, at least one period long
               end_now  = !ph_next && (acc_next >= dbl(len_sel)) &&
                          (acc_next >= dbl(base_clock_period_setting_i));
            end
            // single capture on a whole period, or at the end at latest
            cap_now = (kind_reg == KIND_READ) && !cap_reg &&
                      ((half_tick && !ph_next && (acc_next >= dbl(op_reg))) || end_now);
            if (cap_now) begin
               cap_next = 1'b1;
            end
            if (end_now) begin
               state_next = single_mode_i ? APD_GAP : APD_IDLE;
               gcnt_next  = '0;
            end
         end
         APD_GAP: begin
            if (half_tick) begin
               gcnt_next = gcnt_reg + 2'h1;
               if (gcnt_next == GAP_HALF_STEPS) begin
                  state_next = APD_IDLE;
               end
            end
         end
         default: state_next = APD_IDLE;
      endcase
      // hold off new access while wait is seen; buffer space is also
      // required so a read can never find the buffer full
      rdy_next  = (state_reg == APD_IDLE) && (state_next == APD_IDLE) &&
                  !wait_q_next[1] && buf_in_ready;
      oe_b_next = !((state_next == APD_ACCESS) && (kind_next != KIND_READ));
      busy_next = (state_next != APD_IDLE);
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg  <= APD_IDLE;
         kind_reg   <= KIND_READ;
         wd_reg     <= '0;
         op_reg     <= '0;
         acc_reg    <= '0;
         ph_reg     <= 1'b0;
         div_reg    <= '0;
         wph_reg    <= 1'b0;
         wait_q_reg <= 2'h0;
         cap_reg    <= 1'b0;
         gcnt_reg   <= 2'h0;
         rdy_reg    <= 1'b0;
         oe_b_reg   <= 1'b1;
         busy_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         kind_reg   <= kind_next;
         wd_reg     <= wd_next;
         op_reg     <= op_next;
         acc_reg    <= acc_next;
         ph_reg     <= ph_next;
         div_reg    <= div_next;
         wph_reg    <= wph_next;
         wait_q_reg <= wait_q_next;
         cap_reg    <= cap_next;
         gcnt_reg   <= gcnt_next;
         rdy_reg    <= rdy_next;
         oe_b_reg   <= oe_b_next;
         busy_reg   <= busy_next;
      end
   end

   // ---------------------------------------------------------------
   // control lines
   // ---------------------------------------------------------------
   // read strobe only in reads, write strobe only in writes
   assign line_en = {kind_next != KIND_READ, kind_next == KIND_READ, 2'b11};

   genvar gi;
   generate
      for (gi = 0; gi < LINE_N; gi++) begin : g_line
         always_comb begin
            act_next[gi] = (state_next == APD_ACCESS) && line_en[gi] &&
                           in_win(acc_next, up_a[gi], dn_a[gi]);
            pin_next[gi] = control_polarity_setting_i[gi] ? act_next[gi] : ~act_next[gi];
         end
         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               act_reg[gi] <= 1'b0;
               pin_reg[gi] <= ~POL_RESET[gi];
            end else begin
               act_reg[gi] <= act_next[gi];
               pin_reg[gi] <= pin_next[gi];
            end
         end
      end
   endgenerate

   // read word buffer; a stalled reader holds off the next command
   apd_buf2 u_buf (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (cap_now),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (disp_data_i),
      .out_valid_o (rdata_valid_o),
      .out_ready_i (rdata_ready_i),
      .out_data_o  (rdata_o)
   );

   assign chip_select_o     = pin_reg[LINE_CS];
   assign register_select_o = pin_reg[LINE_RS];
   assign read_strobe_o     = pin_reg[LINE_RD];
   assign write_strobe_o    = pin_reg[LINE_WR];
   assign disp_data_o       = wd_reg;
   assign disp_data_oe_b_o  = oe_b_reg;
   assign cmd_ready_o       = rdy_reg;
   assign busy_o            = busy_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   logic [9:0] len_cnt_reg;
   logic [1:0] cap_cnt_reg;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         len_cnt_reg <= '0;
         cap_cnt_reg <= '0;
      end else begin
         len_cnt_reg <= start ? 10'h001 : ((state_reg == APD_ACCESS) ? len_cnt_reg + 10'h001 : len_cnt_reg);
         cap_cnt_reg <= start ? 2'h0 : (cap_now ? cap_cnt_reg + 2'h1 : cap_cnt_reg);
      end
   end
   wire acc_exit = (state_reg == APD_ACCESS) && (state_next != APD_ACCESS);

   property p_pol_idle;
      (state_reg == APD_IDLE) && $past(state_reg == APD_IDLE) |->
         chip_select_o == ~$past(control_polarity_setting_i[LINE_CS]);
   endproperty
   a_pol_idle: assert property (p_pol_idle) else $error("idle chip select not inactive");
   property p_len_kind;
      acc_exit |-> len_cnt_reg >= {2'h0, len_sel};
   endproperty
   a_len_kind: assert property (p_len_kind) else $error("access shorter than its length");
   property p_len_quant;
      acc_exit |-> len_cnt_reg < {2'h0, len_sel} + {2'h0, base_clock_period_setting_i} + 10'h001;
   endproperty
   a_len_quant: assert property (p_len_quant) else $error("access overran rounding");
   property p_cs_up;
      act_reg[LINE_CS] |-> acc_reg >= dbl(cs_assert_point_i);
   endproperty
   a_cs_up: assert property (p_cs_up) else $error("chip select early");
   property p_cs_dn;
      act_reg[LINE_CS] |-> acc_reg < dbl(cs_release_point_i);
   endproperty
   a_cs_dn: assert property (p_cs_dn) else $error("chip select late release");
   property p_rs_win;
      $rose(act_reg[LINE_RS]) |-> acc_reg >= dbl(rs_assert_point_i) && state_reg == APD_ACCESS;
   endproperty
   a_rs_win: assert property (p_rs_win) else $error("register select early");
   property p_rd_kind;
      act_reg[LINE_RD] |-> kind_reg == KIND_READ && !act_reg[LINE_WR];
   endproperty
   a_rd_kind: assert property (p_rd_kind) else $error("read strobe outside read");
   property p_wr_kind;
      act_reg[LINE_WR] |-> kind_reg != KIND_READ && !disp_data_oe_b_o;
   endproperty
   a_wr_kind: assert property (p_wr_kind) else $error("write strobe outside write");
   property p_cap_once;
      acc_exit && kind_reg == KIND_READ |=> cap_cnt_reg == 2'h1;
   endproperty
   a_cap_once: assert property (p_cap_once) else $error("read capture count wrong");
   property p_cap_op;
      cap_now && !end_now |-> acc_next >= dbl(op_reg);
   endproperty
   a_cap_op: assert property (p_cap_op) else $error("capture before operand point");
   property p_wait_hold;
      wait_q_reg[1] |-> !start;
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("access started under wait");
   property p_gap;
      acc_exit && single_mode_i |=> (state_reg == APD_GAP) && act_reg == 4'h0;
   endproperty
   a_gap: assert property (p_gap) else $error("single mode gap missing");
   property p_clamp;
      act_reg[LINE_RD] |-> acc_reg < dbl(len_sel) + dbl(base_clock_period_setting_i);
   endproperty
   a_clamp: assert property (p_clamp) else $error("read strobe past access end");

   c_read:  cover property (acc_exit && kind_reg == KIND_READ);
   c_write: cover property (acc_exit && kind_reg == KIND_WDATA);
   c_wait:  cover property (wait_q_reg[1] && cmd_valid_i && state_reg == APD_IDLE);
   c_full:  cover property (!buf_in_ready && cmd_valid_i);

endmodule // apd_strobe_gen

//--- apd_strobe_gen_tb.sv
/* apd_strobe_gen_tb: scenario bench for the display strobe generator.
   assumes apd_pkg, the design with its own assertions and apd_disp_model. */
`timescale 1ns/10ps
module apd_strobe_gen_tb import apd_pkg::*; ;
   // ----------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------
   logic              ref_clk_i = 1'b0;
   logic              rst_b_i = 1'b0;
   logic [3:0]        pol = 4'h0;
   logic [TIME_W-1:0] per = 8'h02, lr = 8'h02, la = 8'h05, ld = 8'h0C, s_op = 8'h02;
   logic [TIME_W-1:0] up [4] = '{default: 8'h00};
   logic [TIME_W-1:0] dn [4] = '{default: 8'h02};
   logic              single = 1'b0, cv = 1'b0, rready = 1'b0, stall = 1'b0;
   logic [1:0]        kind = 2'h0;
   logic [DATA_W-1:0] wd = 16'h0000;
   logic              wt, cmd_ready_o, oe_b, rdata_valid_o, busy_o;
   logic [DATA_W-1:0] din, dout, rdata_o, word;
   wire  [3:0]        pin;
   int                mismatches = 0, check_count = 0, rdy_at, oe_n;
   int                first [4], cnt [4];
   // 8 ns reference clock
   always #4 ref_clk_i = ~ref_clk_i;
   apd_strobe_gen i_dut (.ref_clk_i, .rst_b_i, .control_polarity_setting_i(pol),
      .base_clock_period_setting_i(per), .access_len_read_i(lr), .access_len_waddr_i(la),
      .access_len_wdata_i(ld), .cs_assert_point_i(up[LINE_CS]), .cs_release_point_i(dn[LINE_CS]),
      .rs_assert_point_i(up[LINE_RS]), .rs_release_point_i(dn[LINE_RS]),
      .rd_assert_point_i(up[LINE_RD]), .rd_release_point_i(dn[LINE_RD]),
      .wr_assert_point_i(up[LINE_WR]), .wr_release_point_i(dn[LINE_WR]),
      .single_mode_i(single), .cmd_valid_i(cv), .cmd_ready_o, .cmd_kind_i(kind), .cmd_wdata_i(wd),
      .read_capture_operand_i(s_op), .display_wait_input_i(wt), .disp_data_i(din),
      .disp_data_o(dout), .disp_data_oe_b_o(oe_b), .chip_select_o(pin[LINE_CS]),
      .register_select_o(pin[LINE_RS]), .read_strobe_o(pin[LINE_RD]), .write_strobe_o(pin[LINE_WR]),
      .rdata_valid_o, .rdata_ready_i(rready), .rdata_o, .busy_o);
   apd_disp_model i_disp (.ref_clk_i, .rst_b_i, .rd_pin_i(pin[LINE_RD]), .rd_pol_i(pol[LINE_RD]),
      .stall_i(stall), .wait_o(wt), .data_o(din), .word_o(word));
   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   // half-step rounding of a point, in reference cycles
   function automatic int st(int u);
      return ((2 * u + per - 1) / per) * per / 2;
   endfunction
   // ud packs cs, rs, rd, wr as up/down byte pairs
   task automatic cfg(input logic [7:0] p, input logic [3:0] po, input logic [63:0] ud);
      @(posedge ref_clk_i);
      per <= p;
      pol <= po;
      for (int i = 0; i < 4; i++) begin
         up[i] <= ud[63-16*i -: 8];
         dn[i] <= ud[55-16*i -: 8];
      end
      // a polarity flip glitches the idle pins; let the panel settle
      repeat (3) @(posedge ref_clk_i);
   endtask
   // one access, then every line window judged against the settings
   task automatic run(input logic [1:0] k, input int a, input bit full = 1'b0);
      int l, s, e, n, b;
      n = 0;
      b = 0;
      @(posedge ref_clk_i);
      kind <= k;
      cv <= 1'b1;
      do @(negedge ref_clk_i); while (cmd_ready_o !== 1'b1 && ++n < 100);
      @(posedge ref_clk_i);
      cv <= 1'b0;
      first = '{default: -1};
      cnt = '{default: 0};
      rdy_at = -1;
      oe_n = 0;
      for (int c = 0; c < 80; c++) begin
         @(negedge ref_clk_i);
         for (int i = 0; i < 4; i++) if (pin[i] === pol[i]) begin
            if (first[i] < 0) first[i] = c;
            cnt[i]++;
         end
         if (rdy_at < 0 && cmd_ready_o === 1'b1) rdy_at = c;
         if (oe_b === 1'b0) oe_n++;
         if (busy_o === 1'b1) b++;
      end
      l = ((a + per - 1) / per) * per;
      if (l < per) l = per;
      for (int i = 0; i < 4; i++) begin
         s = st(up[i]);
         e = (st(dn[i]) > s) ? st(dn[i]) : s;
         if (e > l) e = l;
         if ((i == LINE_RD && k != KIND_READ) || (i == LINE_WR && k == KIND_READ)) e = s;
         chk(cnt[i], e - s);
         if (e > s) chk(first[i], s);
      end
      // a full read buffer keeps the next command refused
      chk(rdy_at, full ? -1 : l + 1 + (single ? per : 0));
      chk(b, l + (single ? per : 0));
      chk(oe_n, (k != KIND_READ) ? l : 0);
   endtask
   // take one word off the read buffer
   task automatic pop(input logic [DATA_W-1:0] x);
      int n;
      n = 0;
      // step off the edge first: a word moved up on it is not settled yet
      do @(negedge ref_clk_i); while (rdata_valid_o !== 1'b1 && n++ < 50);
      chk(rdata_o, x);
      @(posedge ref_clk_i);
      rready <= 1'b1;
      @(posedge ref_clk_i);
      rready <= 1'b0;
   endtask
   task automatic refused;
      int h;
      h = 0;
      @(posedge ref_clk_i);
      cv <= 1'b1;
      repeat (20) begin
         @(negedge ref_clk_i);
         if (cmd_ready_o === 1'b1) h++;
      end
      @(posedge ref_clk_i);
      cv <= 1'b0;
      chk(h, 0);
   endtask
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_capture;
      logic [DATA_W-1:0] x;
      cfg(8'h02, 4'h0, 64'h0002_0002_0004_0002);
      lr <= 8'h08;
      // operand before and after the strobe ends picks word or released bus
      for (int j = 0; j < 2; j++) begin
         s_op <= j ? 8'h06 : 8'h02;
         x = word;
         run(KIND_READ, 8);
         pop(j ? ~x : x);
      end
   endtask
   task automatic t_write;
      cfg(8'h04, 4'hF, 64'h0103_00FF_00FF_0205);
      for (int k = 1; k < 3; k++) begin
         @(posedge ref_clk_i);
         wd <= 16'h5A00 + k[15:0];
         run(k[1:0], k == 1 ? la : ld);
         chk(dout, 16'h5A00 + k);
         chk(oe_n > 0, 1);
      end
   endtask
   task automatic t_buffer;
      logic [DATA_W-1:0] x0, x1, x2;
      cfg(8'h02, 4'h0, 64'h0002_0002_0002_0002);
      s_op <= 8'h02;
      lr <= 8'h02;
      x0 = word;
      run(KIND_READ, 2);
      x1 = word;
      run(KIND_READ, 2, 1'b1);
      refused();
      pop(x0);
      x2 = word;
      run(KIND_READ, 2, 1'b1);
      pop(x1);
      pop(x2);
   endtask
   task automatic t_wait;
      @(posedge ref_clk_i);
      stall <= 1'b1;
      repeat (16) @(posedge ref_clk_i);
      refused();
      stall <= 1'b0;
      run(KIND_WADDR, la);
   endtask
   task automatic t_single;
      @(posedge ref_clk_i);
      single <= 1'b1;
      run(KIND_WDATA, ld);
      @(posedge ref_clk_i);
      single <= 1'b0;
   endtask
   // ----------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(negedge ref_clk_i);
      chk({pin, busy_o, oe_b, rdata_valid_o}, 7'h7A);
      t_capture();
      t_write();
      t_buffer();
      t_wait();
      t_single();
      summarize();
   end
   // whole run needs under a thousand cycles
   initial begin
      #100000;
      mismatches++;
      summarize();
   end
endmodule // apd_strobe_gen_tb
